// ---- shared/dlt_consts.svh ----
// Register offsets, reset values and fixed codes of the link bring-up block.
`ifndef DLT_CONSTS_SVH
`define DLT_CONSTS_SVH
`define DLT_OFS_LINK_RATE 12'h000
`define DLT_OFS_TP_SET    12'h00c
`define DLT_OFS_SCR_DIS   12'h014
`define DLT_OFS_TX_EN     12'h080
`define DLT_OFS_MAIN_ON   12'h084
`define DLT_OFS_SCR_RST   12'h0c0
`define DLT_OFS_SB_CMD    12'h100
`define DLT_OFS_SB_ADDR   12'h108
`define DLT_OFS_SB_DIV    12'h10c
`define DLT_OFS_SB_STAT   12'h130
`define DLT_OFS_SB_CODE   12'h134
`define DLT_OFS_IRQ_MASK  12'h13c
`define DLT_OFS_CODING    12'h200
`define DLT_OFS_HOLD      12'h21c
`define DLT_OFS_RATE_PICK 12'h220
`define DLT_OFS_READY     12'h280
`define DLT_RST_HOLD      1'h1
`define DLT_RST_MASK      1'h1
`define DLT_RST_CODING    1'h1
`define DLT_RST_DIV       8'h00
// Divisor that turns the 50 MHz bus clock into the 1 MHz sideband tick.
`define DLT_DIV_BUS_MHZ   8'h32
`define DLT_READY_ALL     6'h3f
`define DLT_TP_OFF        2'h0
`define DLT_TP_1          2'h1
`define DLT_TP_2          2'h2
`define DLT_TP_3          2'h3
`define DLT_BS_LAST       9'h1ff
`define DLT_RESP_OK       2'h0
`define DLT_RESP_ERR      2'h2
`endif

// ---- shared/dlt_pkg.sv ----
// Types shared by the link bring-up block.
package dlt_pkg;
   typedef enum logic [2:0] {
      dlt_lane_off,
      dlt_lane_tp1,
      dlt_lane_tp2,
      dlt_lane_tp3,
      dlt_lane_video
   } dlt_lane_mode_t;
endpackage

// ---- core/dlt_link_setup.sv ----
// Source link bring-up: registers, lane pattern choice, scrambler reset, sideband tick.
// Behaviour
// - Training mode blocks video; lanes carry the selected training pattern.
// - Device shows six ready flags; host waits for all before enabling.
// - Writing zero to the mask unmasks hot-plug; host handles plug events.
// - At the fast rate pattern three replaces pattern two.
// - With video on, scrambler resets on every 512th blanking start.
// - Writing one to 0x0c0 resets the scrambler at once.
// - Device divides bus clock by divisor into a 1 MHz sideband tick.
// - Writing the sideband command register launches a request at once.
// - Sink data is reached through sideband registers 0x100 to 0x134.
// - After a reply the device shows the reply code; zero means success.
`timescale 1ns/1ps
`include "dlt_consts.svh"

module dlt_link_setup
   import dlt_pkg::*;
#(
   parameter logic [7:0] RATE_CODE_FAST = 8'h14
)
(
   // Clock and reset.
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   // Register bus, write side.
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // Register bus, read side.
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Serializer control and status.
   input  wire logic [5:0]           serializer_ready_flags,
   output logic                      serializer_hold_ctl,
   output logic [7:0]                lane_rate_pick,
   output logic                      line_coding_en,
   // Lane symbol selection.
   output dlt_lane_mode_t            lane_mode,
   output logic                      scramble_off,
   input  wire logic                 blank_start_sym,
   output logic                      scrambler_reset,
   // Sideband channel engine.
   output logic                      sb_tick,
   output logic                      sb_launch,
   output logic [15:0]               sb_command,
   output logic [19:0]               sb_address,
   input  wire logic                 sb_reply_valid,
   input  wire logic [3:0]           sb_reply_code,
   // Hot-plug event gate.
   output logic                      hpd_unmasked
);

   // Registers written by software, then sideband reply state, counters and bus decode nets.
   logic [7:0]  link_rate_code;
   logic [1:0]  tp_set;
   logic        tx_en;
   logic        main_stream_on;
   logic [7:0]  sideband_tick_divisor;
   logic        irq_mask;
   logic        reply_rcvd;
   logic [3:0]  reply_code;
   logic [7:0]  div_cnt;
   logic [8:0]  bs_cnt;
   logic        wr_go, rd_go, wr_hit, rd_hit;
   logic [31:0] next_rdata;
   dlt_lane_mode_t next_lane_mode;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // One write is taken when address and data meet and no answer is pending.
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   // Write decode; unknown offsets answer with an error.
   always_comb
   begin
      unique case (s_axi_awaddr)
         `DLT_OFS_LINK_RATE, `DLT_OFS_TP_SET, `DLT_OFS_SCR_DIS, `DLT_OFS_TX_EN,
         `DLT_OFS_MAIN_ON, `DLT_OFS_SCR_RST, `DLT_OFS_SB_CMD, `DLT_OFS_SB_ADDR,
         `DLT_OFS_SB_DIV, `DLT_OFS_IRQ_MASK, `DLT_OFS_CODING, `DLT_OFS_HOLD,
         `DLT_OFS_RATE_PICK: wr_hit = 1'b1;
         default:            wr_hit = 1'b0;
      endcase
   end

   // Write answer channel.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DLT_RESP_OK;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `DLT_RESP_OK : `DLT_RESP_ERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Control registers; all gated by the low byte strobe, though the sideband address spans three byte lanes.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         link_rate_code        <= 8'h00;
         tp_set                <= `DLT_TP_OFF;
         scramble_off          <= 1'b0;
         tx_en                 <= 1'b0;
         main_stream_on        <= 1'b0;
         sideband_tick_divisor <= `DLT_RST_DIV;
         irq_mask              <= `DLT_RST_MASK;
         line_coding_en        <= `DLT_RST_CODING;
         serializer_hold_ctl   <= `DLT_RST_HOLD;
         lane_rate_pick        <= 8'h00;
         sb_address            <= 20'h00000;
      end
      else if (wr_go && s_axi_wstrb[0])
      begin
         unique case (s_axi_awaddr)
            `DLT_OFS_LINK_RATE: link_rate_code        <= s_axi_wdata[7:0];
            `DLT_OFS_TP_SET:    tp_set                <= s_axi_wdata[1:0];
            `DLT_OFS_SCR_DIS:   scramble_off          <= s_axi_wdata[0];
            `DLT_OFS_TX_EN:     tx_en                 <= s_axi_wdata[0];
            `DLT_OFS_MAIN_ON:   main_stream_on        <= s_axi_wdata[0];
            `DLT_OFS_SB_DIV:    sideband_tick_divisor <= s_axi_wdata[7:0];
            `DLT_OFS_IRQ_MASK:  irq_mask              <= s_axi_wdata[0];
            `DLT_OFS_CODING:    line_coding_en        <= s_axi_wdata[0];
            `DLT_OFS_HOLD:      serializer_hold_ctl   <= s_axi_wdata[0];
            `DLT_OFS_RATE_PICK: lane_rate_pick        <= s_axi_wdata[7:0];
            `DLT_OFS_SB_ADDR:   sb_address            <= s_axi_wdata[19:0];
            default:            ;
         endcase
      end
   end

   // Hot-plug events pass only while the mask bit is clear.
   assign hpd_unmasked = !irq_mask;

   // Read decode; status reflects the serializer and sideband engine live.
   always_comb
   begin
      next_rdata = 32'h00000000;
      rd_hit     = 1'b1;
      unique case (s_axi_araddr)
         `DLT_OFS_LINK_RATE: next_rdata[7:0]  = link_rate_code;
         `DLT_OFS_TP_SET:    next_rdata[1:0]  = tp_set;
         `DLT_OFS_SCR_DIS:   next_rdata[0]    = scramble_off;
         `DLT_OFS_TX_EN:     next_rdata[0]    = tx_en;
         `DLT_OFS_MAIN_ON:   next_rdata[0]    = main_stream_on;
         `DLT_OFS_SB_CMD:    next_rdata[15:0] = sb_command;
         `DLT_OFS_SB_ADDR:   next_rdata[19:0] = sb_address;
         `DLT_OFS_SB_DIV:    next_rdata[7:0]  = sideband_tick_divisor;
         `DLT_OFS_SB_STAT:   next_rdata[0]    = reply_rcvd;
         `DLT_OFS_SB_CODE:   next_rdata[3:0]  = reply_code;
         `DLT_OFS_IRQ_MASK:  next_rdata[0]    = irq_mask;
         `DLT_OFS_CODING:    next_rdata[0]    = line_coding_en;
         `DLT_OFS_HOLD:      next_rdata[0]    = serializer_hold_ctl;
         `DLT_OFS_RATE_PICK: next_rdata[7:0]  = lane_rate_pick;
         `DLT_OFS_READY:     next_rdata[5:0]  = serializer_ready_flags;
         default:            rd_hit           = 1'b0;
      endcase
   end

   // Read answer channel.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `DLT_RESP_OK;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_hit ? `DLT_RESP_OK : `DLT_RESP_ERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   chk_ready_readback: assert property (
      (rd_go && s_axi_araddr == `DLT_OFS_READY) |=>
         s_axi_rvalid && s_axi_rdata[5:0] == $past(serializer_ready_flags))
      else $error("ready flags read back wrong");
   chk_mask_unmask: assert property (
      (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `DLT_OFS_IRQ_MASK && !s_axi_wdata[0])
         |=> hpd_unmasked)
      else $error("hot-plug not unmasked by zero write");

   // Lane selection: training overrides video, and nothing goes out while the
   // transmitter is off or the serializer is held.
   always_comb
   begin
      if (serializer_hold_ctl || !tx_en)
         next_lane_mode = dlt_lane_off;
      else
         unique case (tp_set)
            `DLT_TP_1: next_lane_mode = dlt_lane_tp1;
            `DLT_TP_2: next_lane_mode = (link_rate_code == RATE_CODE_FAST) ?
                                        dlt_lane_tp3 : dlt_lane_tp2;
            `DLT_TP_3: next_lane_mode = dlt_lane_tp3;
            default:   next_lane_mode = main_stream_on ? dlt_lane_video : dlt_lane_off;
         endcase
   end

   // Registered so the lane datapath sees a clean selector.
   always_ff @(posedge clk_sys)
      if (srst)
         lane_mode <= dlt_lane_off;
      else
         lane_mode <= next_lane_mode;
   chk_off_when_held: assert property (
      (serializer_hold_ctl || !tx_en) |=> lane_mode == dlt_lane_off)
      else $error("lanes driven while transmitter off");
   chk_training_blocks: assert property (
      (tx_en && !serializer_hold_ctl && tp_set == `DLT_TP_1) |=>
         lane_mode == dlt_lane_tp1)
      else $error("training pattern one not selected");
   chk_fast_rate_tp3: assert property (
      (tx_en && !serializer_hold_ctl && tp_set == `DLT_TP_2 &&
       link_rate_code == RATE_CODE_FAST) |=> lane_mode == dlt_lane_tp3)
      else $error("pattern three not used at fast rate");

   // Periodic scrambler alignment; the counter restarts whenever video stops
   // so the first reset after enabling lands a full period later.
   always_ff @(posedge clk_sys)
      if (srst || !main_stream_on)
         bs_cnt <= 9'h000;
      else if (blank_start_sym)
         bs_cnt <= bs_cnt + 9'h001;

   // Forced reset from software or the 512th blanking start.
   always_ff @(posedge clk_sys)
      if (srst)
         scrambler_reset <= 1'b0;
      else
         scrambler_reset <= (wr_go && s_axi_wstrb[0] && s_axi_wdata[0] &&
                             s_axi_awaddr == `DLT_OFS_SCR_RST) ||
                            (main_stream_on && blank_start_sym &&
                             bs_cnt == `DLT_BS_LAST);
   chk_scr_periodic: assert property (
      (main_stream_on && blank_start_sym && bs_cnt == `DLT_BS_LAST) |=> scrambler_reset)
      else $error("scrambler not reset on 512th blanking start");
   chk_scr_forced: assert property (
      (wr_go && s_axi_wstrb[0] && s_axi_wdata[0] && s_axi_awaddr == `DLT_OFS_SCR_RST)
         |=> scrambler_reset)
      else $error("forced scrambler reset missing");

   // Sideband tick: one pulse every divisor cycles; zero acts as one.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         div_cnt <= 8'h00;
         sb_tick <= 1'b0;
      end
      else if (div_cnt + 8'h01 >= sideband_tick_divisor)
      begin
         div_cnt <= 8'h00;
         sb_tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 8'h01;
         sb_tick <= 1'b0;
      end
   end
   chk_tick_period: assert property (
      (sb_tick && sideband_tick_divisor == `DLT_DIV_BUS_MHZ && !wr_go) |=>
         (!sb_tick [*8]) ##42 sb_tick)
      else $error("sideband tick period wrong");

   // Command write launches a request in the very next cycle.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sb_launch  <= 1'b0;
         sb_command <= 16'h0000;
      end
      else
      begin
         sb_launch <= wr_go && s_axi_awaddr == `DLT_OFS_SB_CMD;
         if (wr_go && s_axi_awaddr == `DLT_OFS_SB_CMD)
            sb_command <= s_axi_wdata[15:0];
      end
   end
   chk_launch_now: assert property (
      (wr_go && s_axi_awaddr == `DLT_OFS_SB_CMD) |=> sb_launch)
      else $error("sideband request not launched");

   // Reply flag is sticky; a reply arriving as status is read wins the clear.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         reply_rcvd <= 1'b0;
         reply_code <= 4'h0;
      end
      else if (sb_reply_valid)
      begin
         reply_rcvd <= 1'b1;
         reply_code <= sb_reply_code;
      end
      else if (rd_go && s_axi_araddr == `DLT_OFS_SB_STAT)
         reply_rcvd <= 1'b0;
   end
   chk_reply_code: assert property (
      sb_reply_valid |=> reply_rcvd && reply_code == $past(sb_reply_code))
      else $error("reply code not captured");
endmodule // dlt_link_setup

// ---- testbench/dlt_sink_model.sv ----
// Behavioural far-side partner: serializer readiness flags and sideband replies.
`timescale 1ns/1ps

module dlt_sink_model
#(
   parameter int READY_DLY = 6,
   parameter int REPLY_DLY = 9
)
(
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // Serializer side.
   input  wire logic       serializer_hold_ctl,
   output logic [5:0]      serializer_ready_flags,
   // Sideband side.
   input  wire logic       sb_launch,
   input  wire logic [3:0] reply_pick,
   output logic            sb_reply_valid,
   output logic [3:0]      sb_reply_code
);
   int rdy_cnt;
   int sb_cnt;

   // Lanes report one by one, so a host that waits on a single flag starts too early.
   always_ff @(posedge clk_sys)
   begin
      if (srst || serializer_hold_ctl)
      begin
         rdy_cnt <= 0;
         serializer_ready_flags <= 6'h00;
      end
      else if (rdy_cnt < READY_DLY * 6)
      begin
         rdy_cnt <= rdy_cnt + 1;
         serializer_ready_flags <= 6'((1 << (rdy_cnt / READY_DLY)) - 1);
      end
      else
         serializer_ready_flags <= 6'h3f;
   end

   // Each launch is answered after a fixed delay; between replies the code lines toggle.
   always_ff @(posedge clk_sys)
   begin
      sb_reply_valid <= 1'b0;
      sb_reply_code <= ~sb_reply_code;
      if (srst)
      begin
         sb_cnt <= 0;
         sb_reply_code <= 4'h5;
      end
      else if (sb_launch)
         sb_cnt <= REPLY_DLY;
      else if (sb_cnt > 0)
      begin
         sb_cnt <= sb_cnt - 1;
         if (sb_cnt == 1)
         begin
            sb_reply_valid <= 1'b1;
            sb_reply_code <= reply_pick;
         end
      end
   end
endmodule // dlt_sink_model

// ---- testbench/tb_dlt_link_setup.sv ----
// Self-checking bench for the link bring-up block and its far-side partner.
`timescale 1ns/1ps
`include "dlt_consts.svh"

module tb_dlt_link_setup
   import dlt_pkg::*;
;
   logic           clk_sys = 1'b0;
   logic           srst = 1'b1;
   logic [11:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]    s_axi_wdata, s_axi_rdata;
   logic [3:0]     s_axi_wstrb, sb_reply_code, reply_pick;
   logic [1:0]     s_axi_bresp, s_axi_rresp;
   logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic           s_axi_rvalid, s_axi_rready, serializer_hold_ctl, line_coding_en;
   logic [5:0]     serializer_ready_flags;
   logic [7:0]     lane_rate_pick;
   dlt_lane_mode_t lane_mode;
   logic           scramble_off, blank_start_sym, scrambler_reset, sb_tick;
   logic           sb_launch, sb_reply_valid, hpd_unmasked, launch_at_b, scr_at_b;
   logic [15:0]    sb_command;
   logic [19:0]    sb_address;
   int             fail_count, n_checks, cyc, last, gap, scr_cnt;

   dlt_link_setup #(.RATE_CODE_FAST(8'h14)) i_dlt_link_setup (.clk_sys, .srst,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .serializer_ready_flags, .serializer_hold_ctl,
      .lane_rate_pick, .line_coding_en, .lane_mode, .scramble_off, .blank_start_sym,
      .scrambler_reset, .sb_tick, .sb_launch, .sb_command, .sb_address,
      .sb_reply_valid, .sb_reply_code, .hpd_unmasked);

   dlt_sink_model i_dlt_sink_model (.clk_sys, .srst, .serializer_hold_ctl,
      .serializer_ready_flags, .sb_launch, .reply_pick, .sb_reply_valid, .sb_reply_code);

   // Clock at 50 MHz.
   always #10 clk_sys = ~clk_sys;

   // Watchdog, well beyond the fifteen hundred or so cycles the scenarios need.
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end

   // Tick spacing and scrambler reset pulses are counted here, off the bus tasks.
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (sb_tick === 1'b1)
      begin
         gap <= cyc - last;
         last <= cyc;
      end
      if (scrambler_reset === 1'b1)
         scr_cnt <= scr_cnt + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic wait_neg(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // Bus cycles: requests held until ready is seen, answers taken while valid stands.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && n < 50);
      @(posedge clk_sys);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do
         @(negedge clk_sys);
      while (s_axi_bvalid !== 1'b1 && n++ < 100);
      r = s_axi_bresp;
      launch_at_b = sb_launch;
      scr_at_b = scrambler_reset;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (s_axi_arready !== 1'b1 && n < 50);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do
         @(negedge clk_sys);
      while (s_axi_rvalid !== 1'b1 && n++ < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask

   task automatic w(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      check(r, 2'h0, "write answer");
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      wait_neg(1);
      check(hpd_unmasked, 0, "hpd gate at reset");
      check(lane_mode, dlt_lane_off, "lanes at reset");
      rd(`DLT_OFS_HOLD, d, r);
      check(d, 1, "hold reset");
      rd(`DLT_OFS_CODING, d, r);
      check(d, 1, "coding reset");
      rd(`DLT_OFS_SB_DIV, d, r);
      check(d, 0, "divisor reset");
      rd(`DLT_OFS_SCR_RST, d, r);
      check(r, 2'h2, "read of write-only place");
      wr(12'hffc, 1, r);
      check(r, 2'h2, "unmapped write");
   endtask

   task automatic t_setup();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      w(`DLT_OFS_HOLD, 1);
      w(`DLT_OFS_TX_EN, 0);
      w(`DLT_OFS_SB_DIV, `DLT_DIV_BUS_MHZ);
      w(`DLT_OFS_RATE_PICK, 8'h0a);
      w(`DLT_OFS_HOLD, 0);
      check(lane_rate_pick, 8'h0a, "rate pick");
      n = 0;
      do
      begin
         rd(`DLT_OFS_READY, d, r);
         n++;
      end
      while (d[5:0] !== 6'h3f && n < 100);
      check(d, 32'h3f, "ready flags");
      check(lane_mode, dlt_lane_off, "lanes with transmitter off");
      w(`DLT_OFS_TX_EN, 1);
      w(`DLT_OFS_IRQ_MASK, 0);
      wait_neg(1);
      check(hpd_unmasked, 1, "hpd gate open");
      check(lane_mode, dlt_lane_off, "no pattern and no stream");
      check(line_coding_en, 1, "line coding kept on");
      wait_neg(120);
      check(gap, `DLT_DIV_BUS_MHZ, "tick period");
   endtask

   // One sideband request to the sink, then wait for its answer before going on.
   task automatic sb_req(input logic [31:0] a, input logic [31:0] c);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      w(`DLT_OFS_SB_ADDR, a);
      w(`DLT_OFS_SB_CMD, c);
      n = 0;
      do
      begin
         rd(`DLT_OFS_SB_STAT, d, r);
         n++;
      end
      while (d[0] !== 1'b1 && n < 50);
      check(d[0], 1, "sink answered");
   endtask

   task automatic t_modes();
      dlt_lane_mode_t exp;
      // The fast pass runs first; the slower one stands for the host stepping the rate down.
      for (int f = 0; f < 2; f++)
      begin
         w(`DLT_OFS_LINK_RATE, f ? 8'h0a : 8'h14);
         w(`DLT_OFS_SCR_DIS, 1);
         for (int tp = 1; tp < 4; tp++)
         begin
            sb_req(32'h102, 32'h8000 + tp);
            w(`DLT_OFS_TP_SET, tp);
            wait_neg(1);
            exp = (tp == 1) ? dlt_lane_tp1 : (tp == 3 || !f) ? dlt_lane_tp3 : dlt_lane_tp2;
            check(lane_mode, exp, "pattern on lanes");
            check(scramble_off, 1, "scrambling off");
         end
         sb_req(32'h102, 32'h8000);
         w(`DLT_OFS_TP_SET, 0);
         w(`DLT_OFS_SCR_DIS, 0);
         wait_neg(1);
         check(lane_mode, dlt_lane_off, "training ended");
         check(scramble_off, 0, "scrambling on");
      end
   endtask

   task automatic blanks(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         blank_start_sym <= 1'b1;
         @(posedge clk_sys);
         blank_start_sym <= 1'b0;
      end
      wait_neg(2);
   endtask

   task automatic t_scrambler();
      int base;
      w(`DLT_OFS_SCR_RST, 1);
      check(scr_at_b, 1, "forced scrambler reset");
      w(`DLT_OFS_MAIN_ON, 1);
      wait_neg(1);
      check(lane_mode, dlt_lane_video, "video on lanes");
      base = scr_cnt;
      blanks(511);
      check(scr_cnt - base, 0, "no reset before 512th");
      blanks(1);
      check(scr_cnt - base, 1, "reset on 512th blank start");
   endtask

   task automatic t_sideband();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      for (int k = 0; k < 2; k++)
      begin
         reply_pick <= 4'(k * 2);
         w(`DLT_OFS_SB_ADDR, 32'h100 + k);
         w(`DLT_OFS_SB_CMD, 32'h9000 + k);
         check(launch_at_b, 1, "launch after command");
         check(sb_command, 32'h9000 + k, "command value");
         check(sb_address, 32'h100 + k, "sideband address");
         n = 0;
         do
         begin
            rd(`DLT_OFS_SB_STAT, d, r);
            n++;
         end
         while (d[0] !== 1'b1 && n < 50);
         check(d[0], 1, "reply flag");
         rd(`DLT_OFS_SB_STAT, d, r);
         check(d[0], 0, "flag cleared by read");
         rd(`DLT_OFS_SB_CODE, d, r);
         check(d, k * 2, "reply code");
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence: reset for eight cycles, then the scenarios in bring-up order.
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      blank_start_sym = 1'b0;
      reply_pick = 4'h0;
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_setup();
      t_modes();
      t_scrambler();
      t_sideband();
      w(`DLT_OFS_HOLD, 1);
      wait_neg(1);
      check(lane_mode, dlt_lane_off, "lanes silent while held");
      complete_run();
   end
endmodule // tb_dlt_link_setup
